// ==== hw/pgd_pkg.sv ====
// constants for the pager decoder host packet framer
// assumes a 32-bit apb master and a host serial port master
package pgd_pkg;
    localparam int unsigned PGD_DEPTH = 32;
    localparam int unsigned PGD_AW = 5;
    localparam int unsigned PGD_CW = 6;

    // register byte offsets
    localparam logic [7:0] PGD_OFF_CTRL = 8'h00;
    localparam logic [7:0] PGD_OFF_STAT = 8'h04;

    // control register fields
    localparam int unsigned PGD_CTRL_DECODE = 0;
    localparam int unsigned PGD_CTRL_TIME = 1;
    localparam int unsigned PGD_CTRL_ALL = 2;
    localparam int unsigned PGD_CTRL_COLLAPSE = 3;
    localparam int unsigned PGD_CTRL_AFM_END = 4;

    // status register fields
    localparam int unsigned PGD_STAT_DECODE = 0;
    localparam int unsigned PGD_STAT_AFM = 1;
    localparam int unsigned PGD_STAT_OVF = 2;
    localparam int unsigned PGD_STAT_SHUT = 3;
    localparam int unsigned PGD_STAT_ROAM = 4;
    localparam int unsigned PGD_STAT_LVL_LO = 8;

    // packet identifiers
    localparam logic [7:0] PGD_ID_BIW = 8'h00;
    localparam logic [7:0] PGD_ID_ADDR = 8'h01;

    // block information word format codes
    localparam logic [2:0] PGD_FMT_DATE = 3'h1;
    localparam logic [2:0] PGD_FMT_TIME = 3'h2;
    localparam logic [2:0] PGD_FMT_SYSMSG = 3'h5;

    // address kinds and index bases
    localparam logic [1:0] PGD_AK_USER = 2'h0;
    localparam logic [1:0] PGD_AK_TEMP = 2'h1;
    localparam logic [1:0] PGD_AK_OPER = 2'h2;
    localparam logic [7:0] PGD_AI_TEMP_BASE = 8'h80;
    localparam logic [7:0] PGD_AI_OPER_BASE = 8'h90;

    // vector types and short instruction codes
    localparam logic [2:0] PGD_VT_SECURE = 3'h0;
    localparam logic [2:0] PGD_VT_INSTR = 3'h1;
    localparam logic [2:0] PGD_VT_ALPHA = 3'h5;
    localparam logic [2:0] PGD_VT_HEX = 3'h6;
    localparam logic [2:0] PGD_SI_TEMP = 3'h0;
    localparam logic [2:0] PGD_SI_TEMP_MSN = 3'h2;

    // error limits
    localparam logic [2:0] PGD_ERR_MAX = 3'h2;

    localparam int unsigned PGD_PKT_BITS = 32;
endpackage

// ==== hw/pgd_framer.sv ====
// output packet framer: chooses, buffers and shifts packets to the host
// assumes decoder core word strobes on core_clk, one strobe per cycle,
// and a host serial master driving ser_clk and ser_sel_n from outside
//
// Added by the designer: the register offsets and the APB register port.
module pgd_framer
#(
    parameter int unsigned DEPTH = pgd_pkg::PGD_DEPTH
)
(
    input wire logic core_clk, // system clock
    input wire logic rst, // async reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic ser_clk, // host serial clock pin
    input wire logic ser_sel_n, // host serial select pin
    output logic ser_out, // serial data to host
    output logic ser_out_oe, // serial data drive enable
    input wire logic checksum_disabled, // decoder locked by checksum
    input wire logic [31:0] part_id_pkt, // part identification packet
    input wire logic [31:0] status_pkt, // live status packet
    input wire logic shut_evt, // shutdown packet became pending
    input wire logic [31:0] shut_pkt, // shutdown packet contents
    input wire logic roam_evt, // roaming packet became pending
    input wire logic [31:0] roam_pkt, // roaming packet contents
    input wire logic biw_valid, // block word strobe
    input wire logic biw_first, // first block word of phase
    input wire logic [1:0] biw_phase, // phase a..d
    input wire logic [2:0] biw_format, // word format type
    input wire logic [13:0] biw_info, // information bits
    input wire logic [2:0] biw_errs, // corrected bit error count
    input wire logic biw_chk_fail, // check character failed
    input wire logic addr_valid, // address word strobe
    input wire logic addr_match, // matches an enabled address
    input wire logic [2:0] addr_errs, // address bit error count
    input wire logic [1:0] addr_kind, // user, temporary, operator
    input wire logic [3:0] addr_slot, // slot within its kind
    input wire logic [1:0] addr_phase, // phase a..d
    input wire logic addr_priority, // priority address
    input wire logic addr_long, // programmed long address
    input wire logic addr_second, // second word of a long address
    input wire logic addr_tone, // programmed tone only
    input wire logic [6:0] addr_vec_wn, // vector word number
    input wire logic vec_valid, // vector word strobe
    input wire logic vec_sysmsg, // vector of a system message
    input wire logic [6:0] vec_wn, // vector word number
    input wire logic [1:0] vec_phase, // phase a..d
    input wire logic [2:0] vec_type, // vector type
    input wire logic [15:0] vec_fields, // formatted low vector bits
    input wire logic [2:0] vec_errs, // vector bit error count
    input wire logic vec_bad, // parity, check or value failed
    input wire logic vec_has_msg, // message words follow
    input wire logic msg_valid, // message word strobe
    input wire logic [6:0] msg_wn, // message word number
    input wire logic [1:0] msg_phase, // phase a..d
    input wire logic msg_err, // message word error
    input wire logic [20:0] msg_bits, // message information bits
    output logic decode_on, // decoding enabled
    output logic all_frame_mode // all-frame mode active
);
    import pgd_pkg::*;

    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][31:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
        logic decode_on;
        logic time_bit;
        logic all_bit;
        logic collapse;
        logic afm;
        logic ovf;
        logic shut_pend;
        logic roam_pend;
        logic msg_allow;
        logic [2:0] clk_s;
        logic [2:0] sel_s;
        logic [31:0] shift;
        logic out;
        logic out_oe;
        logic [31:0] rdata;
        logic ready;
        logic err;
    } pgd_state_t;

    pgd_state_t s_r;
    pgd_state_t s_nxt;

    function automatic logic [7:0] pgd_addr_index(input logic [1:0] kind,
        input logic [3:0] slot);
        logic [7:0] base;
        base = 8'h00;
        if (kind == PGD_AK_TEMP)
            base = PGD_AI_TEMP_BASE;
        else if (kind == PGD_AK_OPER)
            base = PGD_AI_OPER_BASE;
        return base | {4'h0, slot};
    endfunction

    function automatic logic pgd_starts_afm(input logic [2:0] vtype,
        input logic [2:0] instr);
        logic hit;
        hit = (vtype == PGD_VT_SECURE) || (vtype == PGD_VT_ALPHA) ||
            (vtype == PGD_VT_HEX);
        if (vtype == PGD_VT_INSTR)
            hit = (instr == PGD_SI_TEMP) || (instr == PGD_SI_TEMP_MSN);
        return hit;
    endfunction

    logic active;
    logic push;
    logic [31:0] push_pkt;
    logic pop;
    logic [31:0] load_pkt;
    logic biw_send;
    logic biw_e;
    logic vec_e;
    logic sel_fall;
    logic clk_fall;
    logic [AW:0] cnt_tmp;

    always_comb
    begin
        s_nxt = s_r;
        active = s_r.decode_on && !checksum_disabled;
        push = 1'b0;
        push_pkt = 32'h0000_0000;
        pop = 1'b0;
        load_pkt = status_pkt;
        biw_send = 1'b0;
        biw_e = 1'b0;
        vec_e = 1'b0;
        cnt_tmp = s_r.count;

        // apb slave, one wait state
        s_nxt.ready = 1'b0;
        s_nxt.err = 1'b0;
        if (psel && penable && !s_r.ready)
        begin
            s_nxt.ready = 1'b1;
            s_nxt.rdata = 32'h0000_0000;
            unique case (paddr[7:0])
                PGD_OFF_CTRL:
                begin
                    s_nxt.rdata[PGD_CTRL_DECODE] = s_r.decode_on;
                    s_nxt.rdata[PGD_CTRL_TIME] = s_r.time_bit;
                    s_nxt.rdata[PGD_CTRL_ALL] = s_r.all_bit;
                    s_nxt.rdata[PGD_CTRL_COLLAPSE] = s_r.collapse;
                end
                PGD_OFF_STAT:
                begin
                    s_nxt.rdata[PGD_STAT_DECODE] = s_r.decode_on;
                    s_nxt.rdata[PGD_STAT_AFM] = s_r.afm;
                    s_nxt.rdata[PGD_STAT_OVF] = s_r.ovf;
                    s_nxt.rdata[PGD_STAT_SHUT] = s_r.shut_pend;
                    s_nxt.rdata[PGD_STAT_ROAM] = s_r.roam_pend;
                    s_nxt.rdata[PGD_STAT_LVL_LO +: AW + 1] = s_r.count;
                end
                default:
                    s_nxt.err = 1'b1;
            endcase
            if (paddr[31:8] != 24'h00_0000)
                s_nxt.err = 1'b1;
        end
        if (psel && penable && s_r.ready && pwrite && !s_r.err)
        begin
            if (paddr[7:0] == PGD_OFF_CTRL)
            begin
                s_nxt.decode_on = pwdata[PGD_CTRL_DECODE];
                s_nxt.time_bit = pwdata[PGD_CTRL_TIME];
                s_nxt.all_bit = pwdata[PGD_CTRL_ALL];
                s_nxt.collapse = pwdata[PGD_CTRL_COLLAPSE];
                if (pwdata[PGD_CTRL_AFM_END])
                    s_nxt.afm = 1'b0;
            end
            else if (pwdata[PGD_STAT_OVF])
                s_nxt.ovf = 1'b0;
        end

        biw_e = (biw_errs > PGD_ERR_MAX) || biw_chk_fail;
        if ((biw_format == PGD_FMT_DATE) || (biw_format == PGD_FMT_TIME) ||
            (biw_format == PGD_FMT_SYSMSG))
            biw_send = s_r.time_bit || s_r.all_bit;
        else
            biw_send = s_r.all_bit;
        if (biw_first)
            biw_send = s_r.collapse;
        vec_e = (vec_errs > PGD_ERR_MAX) || vec_bad;

        if (active)
        begin
            if (biw_valid && biw_send)
            begin
                push = 1'b1;
                push_pkt = {PGD_ID_BIW, biw_e, biw_phase, 2'b00,
                    biw_format, 2'b00, biw_info};
            end
            else if (addr_valid && addr_match && (addr_errs <= PGD_ERR_MAX)
                && (!addr_long || addr_second))
            begin
                push = 1'b1;
                push_pkt = {PGD_ID_ADDR, addr_priority, addr_phase,
                    addr_long, 4'h0, pgd_addr_index(addr_kind, addr_slot),
                    addr_tone && (addr_kind == PGD_AK_USER),
                    (addr_tone && (addr_kind == PGD_AK_USER)) ? 7'h00
                        : addr_vec_wn};
                s_nxt.msg_allow = 1'b0;
            end
            else if (vec_valid && !vec_sysmsg)
            begin
                push = 1'b1;
                push_pkt = {1'b0, vec_wn, vec_e, vec_phase, 2'b00,
                    vec_type, vec_fields};
                s_nxt.msg_allow = !vec_e && vec_has_msg;
                if (!vec_e && pgd_starts_afm(vec_type, vec_fields[2:0]))
                    s_nxt.afm = 1'b1;
            end
            else if (msg_valid && s_r.msg_allow)
            begin
                push = 1'b1;
                push_pkt = {1'b0, msg_wn, msg_err, msg_phase, msg_bits};
            end
        end

        // serial port synchronisers
        s_nxt.clk_s = {s_r.clk_s[1:0], ser_clk};
        s_nxt.sel_s = {s_r.sel_s[1:0], ser_sel_n};
        sel_fall = !s_r.sel_s[1] && s_r.sel_s[2];
        clk_fall = !s_r.clk_s[1] && s_r.clk_s[2];

        if (checksum_disabled)
            load_pkt = part_id_pkt;
        else if (s_r.shut_pend)
            load_pkt = shut_pkt;
        else if (s_r.roam_pend)
            load_pkt = roam_pkt;
        else if (s_r.count != '0)
            load_pkt = s_r.mem[s_r.rd_ptr];

        s_nxt.out_oe = !s_r.sel_s[1];
        if (sel_fall)
        begin
            s_nxt.shift = load_pkt;
            s_nxt.out = load_pkt[PGD_PKT_BITS-1];
            if (!checksum_disabled)
            begin
                if (s_r.shut_pend)
                    s_nxt.shut_pend = 1'b0;
                else if (s_r.roam_pend)
                    s_nxt.roam_pend = 1'b0;
                else if (s_r.count != '0)
                    pop = 1'b1;
            end
        end
        else if (clk_fall && !s_r.sel_s[1])
        begin
            s_nxt.shift = {s_r.shift[30:0], 1'b0};
            s_nxt.out = s_r.shift[30];
        end
        if (shut_evt)
            s_nxt.shut_pend = 1'b1;
        if (roam_evt)
            s_nxt.roam_pend = 1'b1;

        if (pop)
        begin
            s_nxt.rd_ptr = s_r.rd_ptr + 1'b1;
            cnt_tmp = cnt_tmp - 1'b1;
        end
        if (push)
        begin
            if (s_r.count == DEPTH[AW:0] && !pop)
            begin
                s_nxt.decode_on = 1'b0;
                s_nxt.ovf = 1'b1;
                s_nxt.rd_ptr = '0;
                s_nxt.wr_ptr = '0;
                cnt_tmp = '0;
            end
            else
            begin
                s_nxt.mem[s_r.wr_ptr] = push_pkt;
                s_nxt.wr_ptr = s_r.wr_ptr + 1'b1;
                cnt_tmp = cnt_tmp + 1'b1;
            end
        end
        s_nxt.count = cnt_tmp;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.clk_s <= 3'h0;
            s_r.sel_s <= 3'h7;
        end
        else
            s_r <= s_nxt;
    end

    assign prdata = s_r.rdata;
    assign pready = s_r.ready;
    assign pslverr = s_r.err;
    assign ser_out = s_r.out;
    assign ser_out_oe = s_r.out_oe;
    assign decode_on = s_r.decode_on;
    assign all_frame_mode = s_r.afm;
endmodule

// ==== tb/pgd_framer_asserts.sv ====
// checker on the framer's apb, select and mode outputs
// sees only top ports; bound to every pgd_framer instance
module pgd_framer_chk
(
    input wire logic core_clk, // system clock
    input wire logic rst, // async reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic ser_sel_n, // host select pin
    input wire logic ser_out_oe, // serial drive enable
    input wire logic decode_on, // decoding enabled
    input wire logic all_frame_mode // all-frame mode
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic wr0;
    logic bad;
    assign wr0 = psel && penable && pready && pwrite && paddr == 32'h0;
    assign bad = paddr != 32'h0 && paddr != 32'h4;
    a_ready_wait: assert property (psel && $rose(penable) |=> pready)
        else $error("ready missing one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_err_resp: assert property (psel && $rose(penable) && bad
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped access without error");
    a_oe_on: assert property ($fell(ser_sel_n) |-> ##[1:5] ser_out_oe)
        else $error("serial drive not enabled after select");
    a_oe_off: assert property (ser_sel_n [*5] |-> !ser_out_oe)
        else $error("serial drive while deselected");
    a_dec_write: assert property (wr0 |=> decode_on == $past(pwdata[0]))
        else $error("decode enable not written");
    a_dec_rise: assert property ($rose(decode_on) |->
        $past(wr0) && $past(pwdata[0]))
        else $error("decoding restarted without a write");
    a_afm_clear: assert property (wr0 && pwdata[4] |=> !all_frame_mode)
        else $error("all-frame mode not ended by write");
    a_afm_fall: assert property ($fell(all_frame_mode) |->
        $past(wr0) && $past(pwdata[4]))
        else $error("all-frame mode ended without a write");
    cover property (wr0);
    cover property ($fell(ser_sel_n));
    cover property ($rose(all_frame_mode));
endmodule

bind pgd_framer pgd_framer_chk u_chk (.*);

// ==== tb/pgd_host.sv ====
// host processor model reading one packet per select over the serial port
// serial clock stays low between packets, 64 ns period
module pgd_host
(
    output logic ser_clk, // serial clock
    output logic ser_sel_n, // select, active low
    input wire logic ser_out // data from framer
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        ser_clk = 1'b0;
        ser_sel_n = 1'b1;
    end
    // first bit taken is bit 31
    task automatic get(output logic [31:0] v);
        ser_sel_n = 1'b0;
        #40;
        for (int i = 31; i >= 0; i--)
        begin
            ser_clk = 1'b1;
            v[i] = ser_out;
            #32;
            ser_clk = 1'b0;
            #32;
        end
        ser_sel_n = 1'b1;
        #40;
    endtask
endmodule

// ==== tb/tb_pgd_framer.sv ====
// self-checking bench: queue model of the framer against the design
// host model reads packets; apb master drives the control registers
module tb_pgd_framer;
    timeunit 1ns;
    timeprecision 1ps;
    import pgd_pkg::*;
    logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic checksum_disabled = 0, shut_evt = 0, roam_evt = 0, biw_valid = 0;
    logic biw_first = 0, biw_chk_fail = 0, addr_valid = 0, addr_match = 0;
    logic addr_priority = 0, addr_long = 0, addr_second = 0, addr_tone = 0;
    logic vec_valid = 0, vec_sysmsg = 0, vec_bad = 0, vec_has_msg = 0;
    logic msg_valid = 0, msg_err = 0, pready, pslverr, ser_clk, ser_sel_n;
    logic ser_out, ser_out_oe, decode_on, all_frame_mode, se;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rd, part_id_pkt = '0;
    logic [31:0] status_pkt = '0, shut_pkt = '0, roam_pkt = '0, q[$];
    logic [1:0] biw_phase = '0, addr_kind = '0, addr_phase = '0;
    logic [1:0] vec_phase = '0, msg_phase = '0;
    logic [2:0] biw_format = '0, biw_errs = '0, addr_errs = '0;
    logic [2:0] vec_type = '0, vec_errs = '0, tt[6], ii[6];
    logic [13:0] biw_info = '0;
    logic [3:0] addr_slot = '0;
    logic [6:0] addr_vec_wn = '0, vec_wn = '0, msg_wn = '0;
    logic [15:0] vec_fields = '0;
    logic [20:0] msg_bits = '0;
    logic dec = 0, tbit = 0, abit = 0, col = 0, afm = 0, ovf = 0;
    logic shp = 0, rmp = 0, mok = 0;
    int failures = 0, n_tests = 0;

    pgd_framer dut (.*);
    pgd_host host (.ser_clk(ser_clk), .ser_sel_n(ser_sel_n), .ser_out(ser_out));

    initial forever #2.5 core_clk = ~core_clk;

    task automatic end_sim;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(string n, logic [31:0] s, logic [31:0] x);
        n_tests++;
        if (s !== x)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask

    // full buffer: push empties it and stops decoding
    function automatic void push(logic [31:0] x);
        if (dec && q.size() == 32)
        begin
            q.delete();
            dec = 0;
            ovf = 1;
        end
        else if (dec)
            q.push_back(x);
    endfunction

    task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        // no timeout here; an access that never sees pready is ended by the watchdog
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge core_clk);
    endtask

    task automatic reg_chk(logic [31:0] a, logic [31:0] x, logic xe);
        apb(0, a, '0);
        check("rdata", rd, x);
        check("slverr", se, xe);
    endtask

    task automatic ctl(logic [4:0] v);
        apb(1, 32'h0, {27'h0, v});
        {col, abit, tbit, dec} = v[3:0];
        if (v[4])
            afm = 0;
    endtask

    function automatic logic [31:0] stat();
        return {18'h0, 6'(q.size()), 3'h0, rmp, shp, ovf, afm, dec};
    endfunction

    task automatic rdp;
        logic [31:0] v, x;
        if (checksum_disabled)
            x = part_id_pkt;
        else if (shp)
            {x, shp} = {shut_pkt, 1'b0};
        else if (rmp)
            {x, rmp} = {roam_pkt, 1'b0};
        else if (q.size() != 0)
            x = q.pop_front();
        else
            x = status_pkt;
        host.get(v);
        check("packet", v, x);
        @(posedge core_clk);
    endtask

    task automatic block_info_word(logic [2:0] f, logic fst, logic [2:0] er, logic ck);
        logic [13:0] s;
        logic [1:0] p;
        s = $urandom;
        p = $urandom;
        {biw_format, biw_first, biw_errs, biw_chk_fail} <= {f, fst, er, ck};
        {biw_info, biw_phase, biw_valid} <= {s, p, 1'b1};
        @(posedge core_clk);
        biw_valid <= 0;
        if (fst ? col : (f inside {1, 2, 5} ? tbit | abit : abit))
            push({8'h00, er > 2 || ck, p, 2'b00, f, 2'b00, s});
        @(posedge core_clk);
    endtask

    task automatic adr(logic [1:0] k, logic m, logic [2:0] er,
        logic lg, logic sc, logic tn);
        logic [3:0] s;
        logic [1:0] p;
        logic [6:0] w;
        logic pa;
        logic t;
        {s, p, pa} = $urandom;
        w = 2 + $urandom % 86;
        {addr_kind, addr_match, addr_errs, addr_long} <= {k, m, er, lg};
        {addr_second, addr_tone, addr_slot, addr_phase} <= {sc, tn, s, p};
        {addr_priority, addr_vec_wn, addr_valid} <= {pa, w, 1'b1};
        @(posedge core_clk);
        addr_valid <= 0;
        t = tn && k == 0;
        // clean matched words, long sent once
        if (m && er < 3 && !(lg && !sc))
        begin
            mok = 0;
            push({8'h01, pa, p, lg, 4'h0, (k == 0 ? 8'h00 : k == 1 ?
                8'h80 : 8'h90) + s, t, t ? 7'h00 : w});
        end
        @(posedge core_clk);
    endtask

    task automatic vec(logic [2:0] ty, logic [2:0] er, logic bd, logic sy,
        logic hm, logic [2:0] i);
        logic [15:0] fl;
        logic [1:0] p;
        logic [6:0] w;
        logic e;
        {fl, p} = $urandom;
        fl[2:0] = i;
        w = 2 + $urandom % 86;
        {vec_type, vec_errs, vec_bad, vec_sysmsg} <= {ty, er, bd, sy};
        {vec_has_msg, vec_fields, vec_wn, vec_phase} <= {hm, fl, w, p};
        vec_valid <= 1;
        @(posedge core_clk);
        vec_valid <= 0;
        e = er > 2 || bd;
        if (!sy && dec)
        begin
            push({1'b0, w, e, p, 2'b00, ty, fl});
            mok = !e && hm;
            // clean secure, alpha, hex and temporary instruction vectors start all-frame mode
            if (!e && (ty inside {0, 5, 6} || ty == 1 && i inside {0, 2}))
                afm = 1;
        end
        @(posedge core_clk);
    endtask

    task automatic msg(logic er);
        logic [20:0] b;
        logic [1:0] p;
        logic [6:0] w;
        {b, p} = $urandom;
        w = 3 + $urandom % 85;
        {msg_wn, msg_phase, msg_err, msg_bits} <= {w, p, er, b};
        msg_valid <= 1;
        @(posedge core_clk);
        msg_valid <= 0;
        if (mok)
            push({1'b0, w, er, p, b});
        @(posedge core_clk);
    endtask

    // host empties the buffer, then reads a status packet
    task automatic drain;
        while (q.size() != 0 || shp || rmp)
            rdp();
        rdp();
    endtask

    initial
    begin
        #400000;
        failures++;
        end_sim();
    end

    initial
    begin
        tt = '{0, 5, 6, 1, 1, 1};
        ii = '{0, 0, 0, 0, 2, 1};
        void'($urandom(61));
        repeat (10) @(posedge core_clk);
        rst <= 0;
        @(posedge core_clk);
        {status_pkt, part_id_pkt} <= {$urandom, $urandom};
        {shut_pkt, roam_pkt} <= {$urandom, $urandom};
        reg_chk(32'h0, '0, 0);
        reg_chk(32'h4, '0, 0);
        reg_chk(32'h8, '0, 1);
        reg_chk(32'h104, '0, 1);
        rdp();
        ctl(5'h03);
        for (int f = 0; f < 8; f++)
            block_info_word(f, 0, f[0] ? 3'h3 : 3'h0, f[1]);
        ctl(5'h05);
        for (int f = 0; f < 8; f++)
            block_info_word(f, 0, 3'h2, f[2]);
        block_info_word(3'h7, 1, 3'h0, 0);
        ctl(5'h0D);
        block_info_word(3'h7, 1, 3'h0, 0);
        {shut_evt, roam_evt} <= 2'b11;
        @(posedge core_clk);
        {shut_evt, roam_evt, shp, rmp} <= 4'b0011;
        @(posedge core_clk);
        reg_chk(32'h0, {28'h0, col, abit, tbit, dec}, 0);
        reg_chk(32'h4, stat(), 0);
        drain();
        for (int k = 0; k < 3; k++)
            adr(k, 1, 3'h2, 0, 0, 1);
        adr(0, 1, 3'h3, 0, 0, 0);
        adr(0, 0, 3'h0, 0, 0, 0);
        adr(0, 1, 3'h0, 1, 0, 0);
        adr(0, 1, 3'h0, 1, 1, 0);
        for (int j = 0; j < 6; j++)
        begin
            vec(tt[j], 3'h1, 0, 0, 0, ii[j]);
            check("afm", all_frame_mode, afm);
            ctl(5'h15);
            check("afm", all_frame_mode, afm);
        end
        vec(3'h5, 3'h3, 0, 0, 1, 3'h0);
        msg(0);
        vec(3'h5, 3'h0, 0, 1, 0, 3'h0);
        check("afm", all_frame_mode, afm);
        vec(3'h3, 3'h0, 0, 0, 1, 3'h0);
        msg(1);
        drain();
        repeat (33) block_info_word(3'h7, 0, 3'h0, 0);
        check("decode", decode_on, dec);
        reg_chk(32'h4, stat(), 0);
        rdp();
        apb(1, 32'h4, 32'h4);
        ovf = 0;
        checksum_disabled <= 1;
        @(posedge core_clk);
        rdp();
        end_sim();
    end
endmodule
